// >>> verilog/eu_defines.svh
`ifndef EU_DEFINES_SVH
`define EU_DEFINES_SVH
// Register byte offsets on the APB bus.
`define EU_SCTL_OFS 8'h00
`define EU_DATA_OFS 8'h04
`define EU_STAT_OFS 8'h08
`define EU_PCTL_OFS 8'h0C
`define EU_DIVL_OFS 8'h10
`define EU_DIVH_OFS 8'h14
// Serial control register fields.
`define EU_B_SM0 7
`define EU_B_SM1 6
`define EU_B_REN 4
`define EU_B_TN9 3
`define EU_B_RN9 2
`define EU_B_TDF 1
`define EU_B_RDF 0
// Serial status register fields.
`define EU_B_DBE 7
`define EU_B_BRK 3
`define EU_B_FERR 2
`define EU_B_CSEL 0
// Power control register fields.
`define EU_B_RDBL 7
`define EU_B_FEA 6
`define EU_B_BRST 0
// Reset value of every register and flag.
`define EU_RST_BYTE 8'h00
// Oversample ticks per bit, and low bits that make a break.
`define EU_OS_PER_BIT 16
`define EU_BRK_BITS 11
`endif

// >>> verilog/eu_pkg.sv
package eu_pkg;
  // Serial mode, from mode_select_0 and mode_select_1.
  typedef enum logic [1:0] {
    EU_SHIFT,
    EU_ASYNC8,
    EU_FIX9,
    EU_VAR9
  } eu_mode_t;
  // Received character as it leaves the receiver.
  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       ferr;
  } eu_rxchar_t;
endpackage

// >>> verilog/eu_uart.sv
`timescale 1ns/1ns
`include "eu_defines.svh"
// Notes on behaviour
// - Rate from fixed divide, overflow or divisor.
// - Shift mode: data on rxd, clock on txd.
// - Shift mode bit rate is clock/16.
// - 8-bit frame: start, 8 data, stop.
// - 8-bit receive keeps stop in ninth field.
// - 8-bit rate from overflow or divisor.
// - 9-bit frame adds programmable ninth bit.
// - Sent ninth bit comes from tx_ninth_bit.
// - Received ninth bit stored, stop dropped.
// - Fixed 9-bit rate clock/16 or clock/32.
// - Variable 9-bit equals fixed except rate.
// - Variable 9-bit rate from overflow or divisor.
// - Divisor is 16 bits from two bytes.
// - Overflow halved when rate_double_bit clear.
// - Bit 7 shows error or mode select.
// - Eleven low bit times flag a break.
// - Break may reset device into programming mode.
// - Buffered character follows after one stop bit.
// - Buffered: done flag when buffer frees.
// - Buffered: ninth bit latched with data.
module eu_uart (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd_in,
  input  wire logic        t1_ovf,
  output logic             txd,
  output logic             rxd_out,
  output logic             rxd_oe,
  output logic             break_reset,
  output logic             isp_request
);
  // ==========================================================
  // Register bus
  // ==========================================================
  localparam int BRK_TICKS = `EU_BRK_BITS * `EU_OS_PER_BIT;
  logic [7:0] sctl_wr, stat_wr, pctl_wr;    // Plain stored fields.
  logic [7:0] divl, divh;                   // Divisor bytes.
  logic       tdf, rdf, ferr, brk;          // Hardware-set flags.
  logic [7:0] rx_data;                      // Last received byte.
  logic       rn9;                          // rx_ninth_bit.
  logic       acc, wr, mapped;
  logic [31:0] next_prdata;
  eu_pkg::eu_mode_t mode;
  logic       m0, nine, dbe, fea;

  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign mode   = eu_pkg::eu_mode_t'({sctl_wr[`EU_B_SM0], sctl_wr[`EU_B_SM1]});
  assign m0     = (mode == eu_pkg::EU_SHIFT);
  assign nine   = (mode == eu_pkg::EU_FIX9) || (mode == eu_pkg::EU_VAR9);
  // Buffering is never applied in shift mode, whatever software set.
  assign dbe    = stat_wr[`EU_B_DBE] && !m0;
  assign fea    = pctl_wr[`EU_B_FEA];
  assign pready = 1'b1;

  // Address decode; anything else answers with an error.
  always_comb begin
    mapped      = 1'b1;
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `EU_SCTL_OFS: begin
        next_prdata[7:0] = {fea ? ferr : sctl_wr[`EU_B_SM0],
                            sctl_wr[6:4], sctl_wr[`EU_B_TN9], rn9, tdf, rdf};
      end
      `EU_DATA_OFS: next_prdata[7:0] = rx_data;
      `EU_STAT_OFS: begin
        next_prdata[7:0] = {stat_wr[7:4], brk, ferr, stat_wr[1:0]};
      end
      `EU_PCTL_OFS: next_prdata[7:0] = pctl_wr;
      `EU_DIVL_OFS: next_prdata[7:0] = divl;
      `EU_DIVH_OFS: next_prdata[7:0] = divh;
      default:      mapped = 1'b0;
    endcase
  end

  assign pslverr = acc && !mapped;

  // Read data is captured in the setup cycle so it comes from a flop.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
    end
  end

  // Software-owned fields. With the access bit set, bit 7 of the
  // control register is the error flag, so mode_select_0 is kept.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sctl_wr <= `EU_RST_BYTE;
      stat_wr <= `EU_RST_BYTE;
      pctl_wr <= `EU_RST_BYTE;
      divl    <= `EU_RST_BYTE;
      divh    <= `EU_RST_BYTE;
    end else if (wr) begin
      unique case (paddr)
        `EU_SCTL_OFS: begin
          sctl_wr[6:3] <= pwdata[6:3];
          if (!fea) begin
            sctl_wr[`EU_B_SM0] <= pwdata[`EU_B_SM0];
          end
        end
        `EU_STAT_OFS: begin
          stat_wr[`EU_B_DBE]  <= pwdata[`EU_B_DBE];
          stat_wr[`EU_B_CSEL] <= pwdata[`EU_B_CSEL];
        end
        `EU_PCTL_OFS: begin
          pctl_wr[`EU_B_RDBL] <= pwdata[`EU_B_RDBL];
          pctl_wr[`EU_B_FEA]  <= pwdata[`EU_B_FEA];
          pctl_wr[`EU_B_BRST] <= pwdata[`EU_B_BRST];
        end
        `EU_DIVL_OFS: divl <= pwdata[7:0];
        `EU_DIVH_OFS: divh <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Rate generation
  // ==========================================================
  logic [15:0] div_cnt;   // Divisor counter on the oscillator clock.
  logic        brg_tick;  // One pulse per divisor period.
  logic        t1_half;   // Toggles on each overflow.
  logic        fix_ph;    // Halves the clock for the slow fixed rate.
  logic        os_tick;   // Oversample tick, 16 per bit.

  assign brg_tick = (div_cnt >= {divh, divl});

  // Oscillator and CPU clock are both mclk in this block.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt <= 16'h0000;
      t1_half <= 1'b0;
      fix_ph  <= 1'b0;
    end else begin
      div_cnt <= brg_tick ? 16'h0000 : div_cnt + 16'h0001;
      fix_ph  <= !fix_ph;
      if (t1_ovf) begin
        t1_half <= !t1_half;
      end
    end
  end

  // There is no path from any other timer; only these sources exist.
  always_comb begin
    unique case (mode)
      eu_pkg::EU_FIX9: os_tick = pctl_wr[`EU_B_RDBL] || fix_ph;
      eu_pkg::EU_SHIFT: os_tick = 1'b1;
      default: begin
        if (stat_wr[`EU_B_CSEL]) begin
          os_tick = brg_tick;
        end else begin
          os_tick = t1_ovf && (pctl_wr[`EU_B_RDBL] || t1_half);
        end
      end
    endcase
  end

  // ==========================================================
  // Transmitter and shift-mode engine
  // ==========================================================
  logic [10:0] tx_sh;     // Frame shifter, bit 0 on the line.
  logic [3:0]  tx_left;   // Bits left including the current one.
  logic [3:0]  tx_os;     // Tick count within the bit.
  logic        tx_busy;
  logic        m0_rx;     // Shift engine is receiving.
  logic [7:0]  m0_sh;     // Shift-mode receive shifter.
  logic [7:0]  buf_data;  // Double-buffer byte.
  logic        buf_n9;    // Ninth bit latched with it.
  logic        buf_full;
  logic        wr_data, ld_direct, buf_wr, m0_go, bit_end, last, hand;
  logic        frame_end, tdf_set, m0_done, n9_live;

  function automatic logic [10:0] eu_frame(input logic [7:0] d,
                                           input logic n9, input logic md0,
                                           input logic nn);
    if (md0) begin
      eu_frame = {3'b111, d};
    end else begin
      eu_frame = {1'b1, nn ? n9 : 1'b1, d, 1'b0};
    end
  endfunction

  assign wr_data   = wr && (paddr == `EU_DATA_OFS);
  assign ld_direct = wr_data && !tx_busy;
  assign buf_wr    = wr_data && tx_busy && dbe && !buf_full;
  assign m0_go     = m0 && sctl_wr[`EU_B_REN] && !rdf && !tx_busy && !wr_data;
  assign bit_end   = tx_busy && os_tick && (tx_os == 4'hF);
  assign last      = bit_end && (tx_left == 4'h1);
  assign hand      = last && buf_full;
  assign frame_end = last && !m0_rx;
  assign m0_done   = last && m0_rx;
  // In buffered mode the flag means room in the buffer, else frame end.
  assign tdf_set   = dbe ? (hand || ld_direct) : frame_end;
  // Unbuffered, the ninth bit is taken from the register as it goes out.
  assign n9_live   = !dbe && nine && (tx_left == 4'h2);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_sh   <= 11'h7FF;
      tx_left <= 4'h0;
      tx_os   <= 4'h0;
      tx_busy <= 1'b0;
      m0_rx   <= 1'b0;
    end else if (ld_direct) begin
      tx_sh   <= eu_frame(pwdata[7:0], sctl_wr[`EU_B_TN9], m0, nine);
      tx_left <= m0 ? 4'h8 : (nine ? 4'hB : 4'hA);
      tx_os   <= 4'h0;
      tx_busy <= 1'b1;
      m0_rx   <= 1'b0;
    end else if (m0_go) begin
      tx_sh   <= 11'h7FF;
      tx_left <= 4'h8;
      tx_os   <= 4'h0;
      tx_busy <= 1'b1;
      m0_rx   <= 1'b1;
    end else if (tx_busy && os_tick) begin
      tx_os <= tx_os + 4'h1;
      if (hand) begin
        tx_sh   <= eu_frame(buf_data, buf_n9, 1'b0, nine);
        tx_left <= nine ? 4'hB : 4'hA;
      end else if (last) begin
        tx_busy <= 1'b0;
        m0_rx   <= 1'b0;
      end else if (bit_end) begin
        tx_sh   <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'h1;
      end
    end
  end

  // Double buffer: holds one byte and its ninth bit until the hand-off.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      buf_data <= `EU_RST_BYTE;
      buf_n9   <= 1'b0;
      buf_full <= 1'b0;
    end else if (buf_wr) begin
      buf_data <= pwdata[7:0];
      buf_n9   <= sctl_wr[`EU_B_TN9];
      buf_full <= 1'b1;
    end else if (hand) begin
      buf_full <= 1'b0;
    end
  end

  // Shift-mode receive samples at the rising edge of the shift clock.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      m0_sh <= `EU_RST_BYTE;
    end else if (m0_rx && os_tick && tx_os == 4'h7) begin
      m0_sh <= {rxd_in, m0_sh[7:1]};
    end
  end

  // Shift clock is low for the first half of each bit, high after.
  always_comb begin
    if (!tx_busy) begin
      txd = 1'b1;
    end else if (m0) begin
      txd = tx_os[3];
    end else begin
      txd = n9_live ? sctl_wr[`EU_B_TN9] : tx_sh[0];
    end
  end

  assign rxd_out = tx_sh[0];
  assign rxd_oe  = m0 && tx_busy && !m0_rx;

  // ==========================================================
  // Asynchronous receiver and break detector
  // ==========================================================
  logic [10:0] rx_sh;     // Sampled bits, newest at the top.
  logic [3:0]  rx_os, rx_cnt;
  logic        rx_on, rx_samp, rx_fin;
  logic [10:0] rx_w;      // Shifter including this sample.
  logic [7:0]  brk_cnt;   // Low ticks, saturating.
  logic        brk_hit;
  eu_pkg::eu_rxchar_t rxc;

  assign rx_samp = rx_on && os_tick && (rx_os == 4'h7);
  assign rx_w    = {rxd_in, rx_sh[10:1]};
  assign rx_fin  = rx_samp && (rx_cnt == (nine ? 4'hA : 4'h9));
  // Short frames sit one place higher in the shifter.
  always_comb begin
    rxc.data  = nine ? rx_w[8:1] : rx_w[9:2];
    rxc.ninth = nine ? rx_w[9] : rx_w[10];
    rxc.ferr  = !rx_w[10];
  end

  // A start edge that is high again at mid-bit is dropped as noise.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_on  <= 1'b0;
      rx_os  <= 4'h0;
      rx_cnt <= 4'h0;
      rx_sh  <= 11'h000;
    end else if (!rx_on) begin
      if (!m0 && sctl_wr[`EU_B_REN] && !rxd_in && os_tick) begin
        rx_on  <= 1'b1;
        rx_os  <= 4'h1;
        rx_cnt <= 4'h0;
      end
    end else if (os_tick) begin
      rx_os <= rx_os + 4'h1;
      if (rx_samp) begin
        rx_sh  <= rx_w;
        rx_cnt <= rx_cnt + 4'h1;
        if (rx_fin || (rx_cnt == 4'h0 && rxd_in)) begin
          rx_on <= 1'b0;
        end
      end
    end
  end

  // Received byte and ninth field; shift mode has no ninth bit.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_data <= `EU_RST_BYTE;
      rn9     <= 1'b0;
    end else if (rx_fin) begin
      rx_data <= rxc.data;
      rn9     <= rxc.ninth;
    end else if (m0_done) begin
      rx_data <= m0_sh;
    end
  end

  assign brk_hit = os_tick && !rxd_in && !m0 && (brk_cnt == 8'(BRK_TICKS - 1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      brk_cnt <= 8'h00;
    end else if (rxd_in || m0) begin
      brk_cnt <= 8'h00;
    end else if (os_tick && brk_cnt != 8'(BRK_TICKS)) begin
      brk_cnt <= brk_cnt + 8'h01;
    end
  end

  // Break reset is a one-cycle request; the programming-mode request
  // holds until the device reset that it provokes clears it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      break_reset <= 1'b0;
      isp_request <= 1'b0;
    end else begin
      break_reset <= brk_hit && pctl_wr[`EU_B_BRST];
      if (brk_hit && pctl_wr[`EU_B_BRST]) begin
        isp_request <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Flags: a hardware set wins over a software clear in one cycle
  // ==========================================================
  logic clr_sctl, clr_stat;
  assign clr_sctl = wr && (paddr == `EU_SCTL_OFS);
  assign clr_stat = wr && (paddr == `EU_STAT_OFS);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tdf  <= 1'b0;
      rdf  <= 1'b0;
      ferr <= 1'b0;
      brk  <= 1'b0;
    end else begin
      tdf  <= tdf_set || (tdf && !(clr_sctl && !pwdata[`EU_B_TDF]));
      rdf  <= rx_fin || m0_done || (rdf && !(clr_sctl && !pwdata[`EU_B_RDF]));
      ferr <= (rx_fin && rxc.ferr) || (ferr && !(clr_stat && !pwdata[`EU_B_FERR])
              && !(clr_sctl && fea && !pwdata[`EU_B_SM0]));
      brk  <= brk_hit || (brk && !(clr_stat && !pwdata[`EU_B_BRK]));
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  txd_idle_a: assert property (!tx_busy |-> txd)
    else $error("txd not high while idle");
  start_low_a: assert property ($rose(tx_busy) && !m0 && !m0_rx |-> !txd)
    else $error("start bit not low");
  stop_high_a: assert property (tx_busy && !m0 && tx_left == 4'h1 |-> txd)
    else $error("stop bit not high");
  shift_clk_a: assert property ($fell(txd) && m0 && tx_busy |-> !txd [*8] ##1 txd)
    else $error("shift clock half period wrong");
  pin_dir_a: assert property (!m0 |-> !rxd_oe)
    else $error("rxd driven outside shift mode");
  break_flag_a: assert property (brk_hit |=> brk ##1 brk)
    else $error("break not flagged");
  rx_sticky_a: assert property (rdf && !clr_sctl |=> rdf)
    else $error("receive flag lost");
  stop_keep_a: assert property (rx_fin && mode == eu_pkg::EU_ASYNC8
                                |=> rn9 == $past(rxd_in))
    else $error("stop bit not kept");
  dbl_flag_a: assert property (hand && dbe |=> tdf && !buf_full)
    else $error("buffer hand-off flag missing");
  div_wrap_a: assert property (brg_tick |=> div_cnt == 16'h0000)
    else $error("divisor did not reload");

  tx_done_c: cover property (frame_end);
  rx_done_c: cover property (rx_fin && nine);
  brk_c: cover property (break_reset);
  hand_c: cover property (hand);
endmodule // eu_uart

// >>> dv/eu_remote.sv
`timescale 1ns/1ns
// ==========================================
// Remote asynchronous serial device.
// ==========================================
module eu_remote (
  input  wire logic mclk,
  input  wire logic txd,
  output logic      line
);
  int cyc; // Free-running clock count, used to time frame starts.

  // Counts clocks so that frame spacing can be measured.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
  end

  // The line is pulled up, so it rests high outside frames.
  initial begin
    line = 1'b1;
    cyc = 0;
  end

  // Sends nb bits LSB first, bc clocks each, then releases the line.
  task automatic send(input logic [11:0] b, input int nb, input int bc);
    for (int i = 0; i < nb; i++) begin
      line <= b[i];
      repeat (bc) @(posedge mclk);
    end
    line <= 1'b1;
  endtask

  // Waits for a start bit and samples mid-bit; it stops at mid stop bit
  // so that a following frame with no idle gap is still caught.
  task automatic grab(input int nb, input int bc, output logic [11:0] b, output int t0);
    int n;
    b = '0;
    n = 0;
    while (txd !== 1'b0 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    t0 = cyc;
    repeat (bc / 2) @(negedge mclk);
    for (int i = 0; i < nb; i++) begin
      b[i] = txd;
      if (i < nb - 1) begin
        repeat (bc) @(negedge mclk);
      end
    end
  endtask
endmodule // eu_remote

// >>> dv/testbench.sv
`timescale 1ns/1ns
`include "eu_defines.svh"
// ==========================================
// Register-level bench for the serial port.
// ==========================================
module testbench;
  logic        mclk, rst, psel, penable, pwrite, t1_ovf, t1_on;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, txd, rxd_out, rxd_oe, break_reset, isp_request;
  logic        rem_line, rxd_wire, er;
  logic [11:0] fa, fb;
  int          fails, n_compared, brk_seen, ta, tb, per;
  logic [7:0]  ofs [5] = '{`EU_SCTL_OFS, `EU_STAT_OFS, `EU_PCTL_OFS, `EU_DIVL_OFS, `EU_DIVH_OFS};

  // The shared pin: the port drives it only in shift-mode transmit.
  assign rxd_wire = rxd_oe ? rxd_out : rem_line;

  eu_uart DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_in(rxd_wire), .t1_ovf(t1_ovf), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .break_reset(break_reset), .isp_request(isp_request));
  eu_remote u_rem (.mclk(mclk), .txd(txd), .line(rem_line));

  always #10 mclk = ~mclk;
  // Overflow stand-in: a pulse on every second clock while enabled.
  always @(posedge mclk) t1_ovf <= t1_on & ~t1_ovf;
  // Counts break pulses; a level held too long would count more than one.
  always @(posedge mclk) if (break_reset === 1'b1) brk_seen++;

  // ==========================================
  // Shared tasks.
  // ==========================================
  task automatic conclude();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fails++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, {24'h0, e}, rd);
  endtask

  // Sends one byte and checks the whole frame and the done flag after it.
  task automatic txf(input logic [7:0] c, input int nb, input int bc, input logic [11:0] ex);
    wr(`EU_SCTL_OFS, c);
    fork
      u_rem.grab(nb, bc, fb, ta);
      wr(`EU_DATA_OFS, ex[8:1]);
    join
    chk("tx frame", {20'h0, ex}, {20'h0, fb});
    repeat (bc) @(posedge mclk);
    apb(1'b0, `EU_SCTL_OFS, 32'h0);
    chk("tx done", 32'h1, {31'h0, rd[`EU_B_TDF]});
  endtask

  // Collects shift-mode data at each rising edge of the shift clock.
  task automatic shcap();
    int n, tp;
    n = 0;
    tp = 0;
    for (int i = 0; i < 8; i++) begin
      while (txd !== 1'b0 && n < 5000) begin
        @(negedge mclk);
        n++;
      end
      while (txd !== 1'b1 && n < 5000) begin
        @(negedge mclk);
        n++;
      end
      fa[i] = rxd_wire;
      per = u_rem.cyc - tp;
      tp = u_rem.cyc;
    end
    // A shift clock that never toggles is a failure, not a silent pass.
    if (n >= 5000) begin
      fails++;
      conclude();
    end
  endtask

  // Bounds the whole run in case a wait inside the partner hangs.
  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    conclude();
  end

  // ==========================================
  // Main sequence.
  // ==========================================
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    t1_on = 1'b0;
    t1_ovf = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, then an unmapped address that must be refused.
    foreach (ofs[i]) rc(ofs[i], 8'h00, "reset value");
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    wr(`EU_DIVH_OFS, 8'hA5);
    rc(`EU_DIVH_OFS, 8'hA5, "divisor high");
    wr(`EU_DIVH_OFS, 8'h00);
    // Fixed 9-bit mode at both clock fractions, ninth bit set.
    for (int r = 0; r < 2; r++) begin
      wr(`EU_PCTL_OFS, {r[0], 7'h0});
      txf(8'h88, 11, r ? 16 : 32, {2'b01, 1'b1, 8'hA5, 1'b0});
    end
    // Variable 9-bit mode from the divisor: one tick per two clocks.
    wr(`EU_STAT_OFS, 8'h01);
    wr(`EU_DIVL_OFS, 8'h01);
    txf(8'hD0, 11, 32, {2'b01, 1'b0, 8'h3C, 1'b0});
    u_rem.send({2'b01, 1'b0, 8'hC3, 1'b0}, 11, 32);
    repeat (40) @(posedge mclk);
    rc(`EU_DATA_OFS, 8'hC3, "rx data");
    rc(`EU_SCTL_OFS, 8'hD3, "rx flags");
    rc(`EU_SCTL_OFS, 8'hD3, "rx flag held");
    wr(`EU_SCTL_OFS, 8'hD0);
    rc(`EU_SCTL_OFS, 8'hD0, "rx flag cleared");
    // 8-bit mode from timer overflow, with and without halving.
    wr(`EU_STAT_OFS, 8'h00);
    t1_on <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      wr(`EU_PCTL_OFS, {r[0], 7'h0});
      txf(8'h50, 10, r ? 32 : 64, {3'b001, 8'h5A, 1'b0});
      u_rem.send({3'b001, 8'h96, 1'b0}, 10, r ? 32 : 64);
      repeat (80) @(posedge mclk);
      rc(`EU_DATA_OFS, 8'h96, "rx data 8");
      rc(`EU_SCTL_OFS, 8'h57, "rx stop kept");
    end
    t1_on <= 1'b0;
    // Framing error seen in status, and in control bit 7 on request.
    wr(`EU_PCTL_OFS, 8'h00);
    wr(`EU_STAT_OFS, 8'h01);
    wr(`EU_SCTL_OFS, 8'h50);
    u_rem.send({3'b000, 8'h55, 1'b0}, 10, 32);
    repeat (40) @(posedge mclk);
    rc(`EU_STAT_OFS, 8'h05, "frame error");
    apb(1'b0, `EU_SCTL_OFS, 32'h0);
    chk("mode bit", 32'h0, {31'h0, rd[7]});
    wr(`EU_PCTL_OFS, 8'h40);
    apb(1'b0, `EU_SCTL_OFS, 32'h0);
    chk("error bit", 32'h1, {31'h0, rd[7]});
    wr(`EU_SCTL_OFS, 8'h50);
    rc(`EU_STAT_OFS, 8'h01, "error cleared");
    // Ten low bits are not a break; twelve are, and raise the reset request.
    wr(`EU_PCTL_OFS, 8'h01);
    u_rem.send(12'h000, 10, 32);
    repeat (40) @(posedge mclk);
    apb(1'b0, `EU_STAT_OFS, 32'h0);
    chk("no break", 32'h0, {31'h0, rd[`EU_B_BRK]});
    u_rem.send(12'h000, 12, 32);
    repeat (40) @(posedge mclk);
    apb(1'b0, `EU_STAT_OFS, 32'h0);
    chk("break flag", 32'h1, {31'h0, rd[`EU_B_BRK]});
    chk("break pulse", 32'd1, brk_seen);
    chk("isp request", 32'h1, {31'h0, isp_request});
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk("isp after reset", 32'h0, {31'h0, isp_request});
    // Double buffering: second byte queued, ninth bit changed between.
    wr(`EU_STAT_OFS, 8'h81);
    wr(`EU_SCTL_OFS, 8'hC8);
    fork
      begin
        u_rem.grab(11, 16, fa, ta);
        u_rem.grab(11, 16, fb, tb);
      end
      begin
        wr(`EU_DATA_OFS, 8'h11);
        wr(`EU_SCTL_OFS, 8'hC0);
        wr(`EU_DATA_OFS, 8'h22);
        rc(`EU_SCTL_OFS, 8'hC0, "done while full");
      end
    join
    chk("first frame", {20'h0, 2'b01, 1'b1, 8'h11, 1'b0}, {20'h0, fa});
    chk("second frame", {20'h0, 2'b01, 1'b0, 8'h22, 1'b0}, {20'h0, fb});
    chk("frame spacing", 32'd176, tb - ta);
    apb(1'b0, `EU_SCTL_OFS, 32'h0);
    chk("done on hand-off", 32'h1, {31'h0, rd[`EU_B_TDF]});
    // Shift mode: data on the receive pin, clock on the transmit pin.
    wr(`EU_STAT_OFS, 8'h00);
    wr(`EU_SCTL_OFS, 8'h00);
    fork
      shcap();
      wr(`EU_DATA_OFS, 8'h96);
    join
    chk("shift data", 32'h96, {24'h0, fa[7:0]});
    chk("shift period", 32'd16, per);
    conclude();
  end
endmodule // testbench
